// File: rtl/cise_alu.sv
// combinational arithmetic for the instruction subset
`timescale 1ns/1ps
module cise_alu (
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic carry_in,
  input wire logic [1:0] func,
  output logic [7:0] result,
  output logic carry_out,
  output logic zero_out
);
  logic [8:0] wide;
  always_comb begin
    wide = 9'h000;
    unique case (func)
      2'h0: wide = {a[cise_pkg::MSB], a[6:0], carry_in};
      2'h1: wide = {1'b0, a} + {1'b0, a};
      2'h2: wide = {1'b0, a} - {1'b0, b};
      2'h3: wide = {carry_in, a | b};
    endcase
    result = wide[7:0];
    // borrow bit doubles as carry when acc < src
    carry_out = wide[8];
    zero_out = (wide[7:0] == 8'h00);
  end
endmodule

// File: rtl/cise_core.sv
// decode and execute of the instruction subset with standby control
`timescale 1ns/1ps
module cise_core (
  input wire logic clk,
  input wire logic reset_n,
  input wire cise_pkg::cise_instr_t instr,
  input wire logic [11:0] stack_top,
  input wire logic stack_empty,
  input wire logic ext_irq,
  input wire logic periph_irq,
  input wire logic nmi_take,
  input wire logic std_take,
  output logic busy,
  output logic [7:0] acc,
  output logic [11:0] pc,
  output logic stack_pop,
  output logic mem_we,
  output logic [7:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic irq_mask,
  output logic osc_run,
  output logic halted,
  output cise_pkg::cise_flags_t flags_out,
  output logic [1:0] flag_ctx
);
  typedef enum {CISE_RUN, CISE_EXEC, CISE_LIGHT, CISE_DEEP} cise_state_t;
  cise_state_t state, next_state;
  logic [2:0] cnt, next_cnt;
  logic [7:0] next_acc;
  logic [11:0] next_pc;
  logic next_stack_pop, next_mem_we, next_irq_mask, next_osc_run, next_halted, next_busy;
  logic [7:0] next_mem_addr, next_mem_wdata;
  logic [1:0] next_flag_ctx, nmi_from, next_nmi_from, alu_f;
  cise_pkg::cise_flags_t fl [3], next_fl [3], next_flags_out;
  logic [1:0] ext_sync, per_sync;
  logic [7:0] alu_b, alu_r, src;
  logic alu_c, alu_z;
  // wake sources come from pins: only stage [1] is read by logic
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_sync <= 2'h0;
      per_sync <= 2'h0;
    end else begin
      ext_sync <= {ext_sync[0], ext_irq};
      per_sync <= {per_sync[0], periph_irq};
    end
  end
  function automatic logic [7:0] pick_src(input cise_pkg::cise_instr_t i, input logic [7:0] a);
    unique case (i.opnd)
      cise_pkg::OPND_ACC: pick_src = a;
      cise_pkg::OPND_X: pick_src = i.x_data;
      cise_pkg::OPND_Y: pick_src = i.y_data;
      cise_pkg::OPND_V: pick_src = i.v_data;
      cise_pkg::OPND_W: pick_src = i.w_data;
      default: pick_src = i.mem_data;
    endcase
  endfunction

  always_comb begin
    src = pick_src(instr, acc);
    alu_f = 2'h2;
    alu_b = instr.mem_data;
    if (instr.op == cise_pkg::OP_ROTATE_LEFT) begin
      alu_f = 2'h0;
    end else if (instr.op == cise_pkg::OP_PREFIX_ALU) begin
      alu_f = 2'h1;
    end else if (instr.op[4:0] == cise_pkg::OP_BIT_SET_LOW) begin
      alu_f = 2'h3;
      alu_b = 8'h01 << instr.op[7:5];
    end else if (instr.op == cise_pkg::OP_MINUS_IMMEDIATE) begin
      alu_b = instr.opnd;
    end else if (instr.op == cise_pkg::OP_PREFIX_SUB) begin
      alu_b = src;
    end
  end
  cise_alu u_alu (
    .a((instr.op[4:0] == cise_pkg::OP_BIT_SET_LOW) ? src : acc),
    .b(alu_b),
    .carry_in(fl[flag_ctx].carry),
    .func(alu_f),
    .result(alu_r),
    .carry_out(alu_c),
    .zero_out(alu_z)
  );
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_acc = acc;
    next_pc = pc;
    next_stack_pop = 1'b0;
    next_mem_we = 1'b0;
    next_mem_addr = mem_addr;
    next_mem_wdata = mem_wdata;
    next_irq_mask = irq_mask;
    next_osc_run = osc_run;
    next_halted = halted;
    next_flag_ctx = flag_ctx;
    next_nmi_from = nmi_from;
    for (int k = 0; k < 3; k++) begin
      next_fl[k] = fl[k];
    end
    unique case (state)
      CISE_RUN: begin
        if (nmi_take) begin
          next_nmi_from = flag_ctx;
          next_flag_ctx = cise_pkg::CTX_NMI;
          next_irq_mask = 1'b1;
        end else if (std_take && !irq_mask) begin
          next_flag_ctx = cise_pkg::CTX_STD;
          next_irq_mask = 1'b1;
        end else if (instr.valid) begin
          next_state = CISE_EXEC;
          next_cnt = cise_pkg::CYC_LONG - 3'h1;
          unique case (instr.op)
            cise_pkg::OP_INTERRUPT_RETURN: begin
              next_cnt = cise_pkg::CYC_SHORT - 3'h1;
              if (!stack_empty) begin
                next_pc = stack_top;
                next_stack_pop = 1'b1;
              end else begin
                next_pc = pc + 12'h001;
              end
              if (flag_ctx == cise_pkg::CTX_NMI) begin
                next_flag_ctx = nmi_from;
              end else begin
                next_flag_ctx = cise_pkg::CTX_NORMAL;
              end
              next_irq_mask = 1'b0;
            end
            cise_pkg::OP_STANDBY_DEEP: begin
              next_cnt = cise_pkg::CYC_SHORT - 3'h1;
              next_state = CISE_DEEP;
              next_osc_run = 1'b0;
              next_halted = 1'b1;
              next_pc = pc + 12'h001;
            end
            cise_pkg::OP_STANDBY_LIGHT: begin
              next_state = CISE_LIGHT;
              next_halted = 1'b1;
              next_pc = pc + 12'h001;
            end
            cise_pkg::OP_ROTATE_LEFT, cise_pkg::OP_PREFIX_ALU: begin
              next_acc = alu_r;
              next_fl[flag_ctx] = '{zero: alu_z, carry: alu_c};
              next_pc = pc + ((instr.op == cise_pkg::OP_ROTATE_LEFT) ? 12'h001 : 12'h002);
            end
            cise_pkg::OP_PREFIX_SUB, cise_pkg::OP_SUB_IND_X, cise_pkg::OP_SUB_IND_Y,
            cise_pkg::OP_MINUS_IMMEDIATE: begin
              next_acc = alu_r;
              next_fl[flag_ctx] = '{zero: alu_z, carry: alu_c};
              next_pc = pc + ((instr.op[3:0] == 4'h7 && instr.op[7:4] == 4'hC ||
                instr.op == cise_pkg::OP_SUB_IND_Y) ? 12'h001 : 12'h002);
            end
            default: begin
              if (instr.op[4:0] == cise_pkg::OP_BIT_SET_LOW) begin
                next_pc = pc + 12'h002;
                if (instr.opnd == cise_pkg::OPND_ACC) begin
                  next_acc = alu_r;
                end else begin
                  next_mem_we = 1'b1;
                  next_mem_addr = instr.opnd;
                  next_mem_wdata = alu_r;
                end
              end else begin
                next_state = CISE_RUN;
              end
            end
          endcase
        end
      end
      CISE_EXEC: begin
        if (cnt <= 3'h1) begin
          next_state = CISE_RUN;
        end
        next_cnt = cnt - 3'h1;
      end
      CISE_LIGHT: begin
        if (per_sync[1] || ext_sync[1]) begin
          next_state = CISE_RUN;
          next_halted = 1'b0;
        end
      end
      CISE_DEEP: begin
        // only external wake; software must stop converter itself
        if (ext_sync[1]) begin
          next_state = CISE_RUN;
          next_halted = 1'b0;
          next_osc_run = 1'b1;
        end
      end
    endcase
    next_flags_out = next_fl[next_flag_ctx];
    next_busy = (next_state != CISE_RUN);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= CISE_RUN;
      cnt <= 3'h0;
      acc <= cise_pkg::ACC_RESET;
      pc <= cise_pkg::PC_RESET;
      stack_pop <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 8'h00;
      mem_wdata <= 8'h00;
      irq_mask <= 1'b1;
      osc_run <= 1'b1;
      halted <= 1'b0;
      flag_ctx <= cise_pkg::CTX_NMI;
      busy <= 1'b0;
      nmi_from <= cise_pkg::CTX_NORMAL;
      flags_out <= '0;
      for (int k = 0; k < 3; k++) begin
        fl[k] <= '0;
      end
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      acc <= next_acc;
      pc <= next_pc;
      stack_pop <= next_stack_pop;
      mem_we <= next_mem_we;
      mem_addr <= next_mem_addr;
      mem_wdata <= next_mem_wdata;
      irq_mask <= next_irq_mask;
      osc_run <= next_osc_run;
      halted <= next_halted;
      flag_ctx <= next_flag_ctx;
      busy <= next_busy;
      nmi_from <= next_nmi_from;
      flags_out <= next_flags_out;
      for (int k = 0; k < 3; k++) begin
        fl[k] <= next_fl[k];
      end
    end
  end

  sequence s_ret_taken;
    state == CISE_RUN && instr.valid && !nmi_take && !std_take &&
      instr.op == cise_pkg::OP_INTERRUPT_RETURN;
  endsequence

  a_ret_mask_clear: assert property (@(posedge clk) disable iff (!reset_n)
    s_ret_taken |=> !irq_mask) else $error("mask not cleared by return");
  a_ret_pc_pop: assert property (@(posedge clk) disable iff (!reset_n)
    s_ret_taken and !stack_empty |=> pc == $past(stack_top) && stack_pop)
    else $error("return did not pop pc");
  a_ret_empty_stack: assert property (@(posedge clk) disable iff (!reset_n)
    s_ret_taken and stack_empty |=> pc == $past(pc) + 12'h001 && !stack_pop)
    else $error("empty stack return moved pc");
  a_ret_normal_ctx: assert property (@(posedge clk) disable iff (!reset_n)
    s_ret_taken and flag_ctx == cise_pkg::CTX_STD |=> flag_ctx == cise_pkg::CTX_NORMAL)
    else $error("return left interrupt flags active");
  a_deep_osc_off: assert property (@(posedge clk) disable iff (!reset_n)
    state == CISE_RUN && instr.valid && !nmi_take && !std_take &&
    instr.op == cise_pkg::OP_STANDBY_DEEP |=> !osc_run && halted)
    else $error("deep standby kept oscillator");
  a_deep_no_per_wake: assert property (@(posedge clk) disable iff (!reset_n)
    state == CISE_DEEP && !ext_sync[1] |=> state == CISE_DEEP)
    else $error("deep standby woke without external irq");
  a_light_wake: assert property (@(posedge clk) disable iff (!reset_n)
    state == CISE_LIGHT && per_sync[1] |=> !halted) else $error("light standby missed wake");
  a_light_osc_on: assert property (@(posedge clk) disable iff (!reset_n)
    state == CISE_LIGHT |-> osc_run) else $error("light standby stopped oscillator");
  a_long_busy: assert property (@(posedge clk) disable iff (!reset_n)
    state == CISE_RUN && instr.valid && !nmi_take && !std_take &&
    instr.op == cise_pkg::OP_ROTATE_LEFT |=> busy [*3] ##1 !busy)
    else $error("rotate not four cycles");
endmodule

// File: rtl/cise_pkg.sv
// constants and carrier types for the instruction subset executor
package cise_pkg;
  localparam logic [7:0] OP_INTERRUPT_RETURN = 8'h4D;
  localparam logic [7:0] OP_ROTATE_LEFT = 8'hAD;
  localparam logic [4:0] OP_BIT_SET_LOW = 5'h1B;
  localparam logic [7:0] OP_PREFIX_ALU = 8'h5F;
  localparam logic [7:0] OP_PREFIX_SUB = 8'hDF;
  localparam logic [7:0] OP_SUB_IND_X = 8'hC7;
  localparam logic [7:0] OP_SUB_IND_Y = 8'hCF;
  localparam logic [7:0] OP_MINUS_IMMEDIATE = 8'hD7;
  localparam logic [7:0] OP_STANDBY_DEEP = 8'h6D;
  localparam logic [7:0] OP_STANDBY_LIGHT = 8'hED;
  localparam logic [7:0] OPND_ACC = 8'hFF;
  localparam logic [7:0] OPND_X = 8'h80;
  localparam logic [7:0] OPND_Y = 8'h81;
  localparam logic [7:0] OPND_V = 8'h82;
  localparam logic [7:0] OPND_W = 8'h83;
  localparam logic [2:0] CYC_SHORT = 3'h2;
  localparam logic [2:0] CYC_LONG = 3'h4;
  localparam int MSB = 7;
  localparam logic [1:0] CTX_NORMAL = 2'h0;
  localparam logic [1:0] CTX_STD = 2'h1;
  localparam logic [1:0] CTX_NMI = 2'h2;
  localparam logic [11:0] PC_RESET = 12'h000;
  localparam logic [7:0] ACC_RESET = 8'h00;

  typedef struct packed {
    logic zero;
    logic carry;
  } cise_flags_t;

  typedef struct packed {
    logic valid;
    logic [7:0] op;
    logic [7:0] opnd;
    logic [7:0] mem_data;
    logic [7:0] x_data;
    logic [7:0] y_data;
    logic [7:0] v_data;
    logic [7:0] w_data;
  } cise_instr_t;
endpackage

// File: tb/tb.sv
// self-checking bench for the instruction subset executor
`timescale 1ns/1ps
module tb;
  typedef struct {
    logic [7:0] acc;
    logic [11:0] pc;
    cise_pkg::cise_flags_t fl;
    logic [1:0] ctx;
    logic mask;
    int cyc;
    logic we;
    logic [7:0] wa;
    logic [7:0] wd;
    logic pop;
    logic halt;
    logic osc;
  } cise_note_t;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  cise_pkg::cise_instr_t instr = '0;
  logic [11:0] stack_top = 12'h000;
  logic stack_empty = 1'b1;
  logic ext_irq = 1'b0;
  logic periph_irq = 1'b0;
  logic nmi_take = 1'b0;
  logic std_take = 1'b0;
  logic busy, stack_pop, mem_we, irq_mask, osc_run, halted;
  logic [7:0] acc, mem_addr, mem_wdata;
  logic [11:0] pc;
  logic [1:0] flag_ctx;
  cise_pkg::cise_flags_t flags_out;
  int err_total = 0;
  int n_checks = 0;
  integer seed = 74710;
  cise_note_t q[$];
  cise_note_t cur;
  logic bq = 1'b0;
  logic act = 1'b0;
  int cnt = 0;
  logic [7:0] m_acc = 8'h00;
  logic [11:0] m_pc = 12'h000;
  cise_pkg::cise_flags_t m_fl [3] = '{default: 2'h0};
  logic [1:0] m_ctx = cise_pkg::CTX_NMI;
  logic [1:0] m_from = cise_pkg::CTX_NORMAL;
  logic m_mask = 1'b1;

  always #50 clk = ~clk;

  cise_core DUT (.clk(clk), .reset_n(reset_n), .instr(instr), .stack_top(stack_top),
    .stack_empty(stack_empty), .ext_irq(ext_irq), .periph_irq(periph_irq),
    .nmi_take(nmi_take), .std_take(std_take), .busy(busy), .acc(acc), .pc(pc),
    .stack_pop(stack_pop), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .irq_mask(irq_mask), .osc_run(osc_run), .halted(halted), .flags_out(flags_out),
    .flag_ctx(flag_ctx));

  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic idle();
    int k;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (busy !== 1'b0 && k < 20);
    chk("busy_end", 12'h000, busy);
  endtask

  task automatic run(input logic [7:0] op, input logic [7:0] opnd);
    cise_pkg::cise_instr_t i;
    cise_note_t n;
    logic [7:0] src, res;
    logic cy, upd;
    int by;
    i = '{1'b1, op, opnd, 8'($random(seed)), 8'($random(seed)), 8'($random(seed)),
      8'($random(seed)), 8'($random(seed))};
    n = '{default: '0};
    n.osc = 1'b1;
    n.cyc = 3;
    by = 2;
    upd = 1'b1;
    cy = 1'b0;
    res = m_acc;
    if (op == cise_pkg::OP_ROTATE_LEFT) begin
      by = 1;
      res = {m_acc[6:0], m_fl[m_ctx].carry};
      cy = m_acc[7];
    end else if (op == cise_pkg::OP_PREFIX_ALU) begin
      res = {m_acc[6:0], 1'b0};
      cy = m_acc[7];
    end else if (op[4:0] == cise_pkg::OP_BIT_SET_LOW) begin
      upd = 1'b0;
      if (opnd == cise_pkg::OPND_ACC) res = m_acc | (8'h01 << op[7:5]);
      else begin
        n.we = 1'b1;
        n.wa = opnd;
        n.wd = i.mem_data | (8'h01 << op[7:5]);
      end
    end else if (op == cise_pkg::OP_INTERRUPT_RETURN) begin
      by = 1;
      n.cyc = 1;
      upd = 1'b0;
      n.pop = ~stack_empty;
      m_ctx = (m_ctx == cise_pkg::CTX_NMI) ? m_from : cise_pkg::CTX_NORMAL;
      m_mask = 1'b0;
    end else if (op == cise_pkg::OP_STANDBY_DEEP || op == cise_pkg::OP_STANDBY_LIGHT) begin
      by = 1;
      n.cyc = 0;
      upd = 1'b0;
      n.halt = 1'b1;
      n.osc = (op == cise_pkg::OP_STANDBY_LIGHT);
    end else begin
      // source select for subtraction
      if (op == cise_pkg::OP_MINUS_IMMEDIATE) src = opnd;
      else if (op != cise_pkg::OP_PREFIX_SUB) src = i.mem_data;
      else if (opnd == cise_pkg::OPND_ACC) src = m_acc;
      else if (opnd == cise_pkg::OPND_X) src = i.x_data;
      else if (opnd == cise_pkg::OPND_Y) src = i.y_data;
      else if (opnd == cise_pkg::OPND_V) src = i.v_data;
      else if (opnd == cise_pkg::OPND_W) src = i.w_data;
      else src = i.mem_data;
      if (op == cise_pkg::OP_SUB_IND_X || op == cise_pkg::OP_SUB_IND_Y) by = 1;
      res = m_acc - src;
      cy = (m_acc < src);
    end
    if (n.pop) m_pc = stack_top;
    else m_pc = m_pc + 12'(by);
    m_acc = res;
    if (upd) m_fl[m_ctx] = '{zero: (res == 8'h00), carry: cy};
    n.acc = m_acc;
    n.pc = m_pc;
    n.fl = m_fl[m_ctx];
    n.ctx = m_ctx;
    n.mask = m_mask;
    q.push_back(n);
    instr = i;
    @(negedge clk);
    instr.valid = 1'b0;
    if (!n.halt) idle();
  endtask

  task automatic take(input logic nmi);
    if (nmi) nmi_take = 1'b1;
    else std_take = 1'b1;
    @(negedge clk);
    nmi_take = 1'b0;
    std_take = 1'b0;
    if (nmi) m_from = m_ctx;
    m_ctx = nmi ? cise_pkg::CTX_NMI : cise_pkg::CTX_STD;
    m_mask = 1'b1;
    chk("take_ctx", m_ctx, flag_ctx);
    chk("take_mask", 12'h001, irq_mask);
    repeat (4) @(negedge clk);
  endtask

  // results land one cycle after the take; final state once busy drops
  always @(negedge clk) begin
    if (busy === 1'b1 && !bq && q.size() > 0) begin
      cur = q.pop_front();
      act = 1'b1;
      cnt = 0;
      chk("mem_we", cur.we, mem_we);
      if (cur.we) chk("mem_addr", cur.wa, mem_addr);
      if (cur.we) chk("mem_wdata", cur.wd, mem_wdata);
      chk("stack_pop", cur.pop, stack_pop);
      chk("halted", cur.halt, halted);
      chk("osc_run", cur.osc, osc_run);
    end
    if (busy === 1'b1) cnt++;
    else if (bq && act) begin
      act = 1'b0;
      if (cur.cyc > 0) chk("busy_len", 12'(cur.cyc), 12'(cnt));
      chk("acc", cur.acc, acc);
      chk("pc", cur.pc, pc);
      chk("flags", cur.fl, flags_out);
      chk("flag_ctx", cur.ctx, flag_ctx);
      chk("irq_mask", cur.mask, irq_mask);
      chk("halted_end", 12'h000, halted);
      chk("osc_end", 12'h001, osc_run);
    end
    bq = (busy === 1'b1);
  end

  initial begin
    #(100 * 20000);
    err_total++;
    results();
  end

  initial begin
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    chk("rst_ctx", cise_pkg::CTX_NMI, flag_ctx);
    chk("rst_mask", 12'h001, irq_mask);
    chk("rst_acc", cise_pkg::ACC_RESET, acc);
    chk("rst_pc", cise_pkg::PC_RESET, pc);
    run(cise_pkg::OP_INTERRUPT_RETURN, 8'h00);
    for (int r = 0; r < 6; r++) begin
      for (int t = 0; t < 13; t++) begin
        case (t)
          0: run(cise_pkg::OP_ROTATE_LEFT, 8'h00);
          1: run(cise_pkg::OP_PREFIX_ALU, cise_pkg::OPND_ACC);
          2: run(cise_pkg::OP_PREFIX_SUB, cise_pkg::OPND_ACC);
          3: run(cise_pkg::OP_PREFIX_SUB, cise_pkg::OPND_X);
          4: run(cise_pkg::OP_PREFIX_SUB, cise_pkg::OPND_Y);
          5: run(cise_pkg::OP_PREFIX_SUB, cise_pkg::OPND_V);
          6: run(cise_pkg::OP_PREFIX_SUB, cise_pkg::OPND_W);
          7: run(cise_pkg::OP_PREFIX_SUB, 8'($random(seed)) & 8'h7F);
          8: run(cise_pkg::OP_SUB_IND_X, 8'h00);
          9: run(cise_pkg::OP_SUB_IND_Y, 8'h00);
          10: run(cise_pkg::OP_MINUS_IMMEDIATE, 8'($random(seed)));
          11: run({3'(r), cise_pkg::OP_BIT_SET_LOW}, cise_pkg::OPND_ACC);
          default: run({3'(r + 2), cise_pkg::OP_BIT_SET_LOW}, 8'($random(seed)) & 8'h7F);
        endcase
      end
    end
    take(1'b0);
    run(cise_pkg::OP_MINUS_IMMEDIATE, 8'($random(seed)));
    take(1'b1);
    run(cise_pkg::OP_ROTATE_LEFT, 8'h00);
    stack_empty = 1'b0;
    stack_top = 12'($random(seed));
    run(cise_pkg::OP_INTERRUPT_RETURN, 8'h00);
    stack_top = 12'($random(seed));
    run(cise_pkg::OP_INTERRUPT_RETURN, 8'h00);
    stack_empty = 1'b1;
    run(cise_pkg::OP_STANDBY_LIGHT, 8'h00);
    repeat (3) @(negedge clk);
    periph_irq = 1'b1;
    idle();
    periph_irq = 1'b0;
    run(cise_pkg::OP_STANDBY_DEEP, 8'h00);
    repeat (2) @(negedge clk);
    periph_irq = 1'b1;
    repeat (8) @(negedge clk);
    chk("deep_hold", 12'h001, halted);
    periph_irq = 1'b0;
    ext_irq = 1'b1;
    idle();
    ext_irq = 1'b0;
    repeat (3) @(negedge clk);
    results();
  end
endmodule
